// ==== common/ppo_pkg.sv ====
// package for the print protocol options block
// assumes a decoded command port drives the block; no register bus
package ppo_pkg;
    // ============================================================
    // command codes
    localparam logic [2:0] CMD_SET_TEMPCO   = 3'h1;
    localparam logic [2:0] CMD_SET_TIME     = 3'h2;
    localparam logic [2:0] CMD_SET_TYPE     = 3'h3;
    localparam logic [2:0] CMD_SET_COMP     = 3'h4;
    localparam logic [2:0] CMD_QRY_TEMPCO   = 3'h5;
    localparam logic [2:0] CMD_QRY_TIME     = 3'h6;
    localparam logic [2:0] CMD_QRY_TYPE     = 3'h7;
    // ============================================================
    // printer type codes and line widths
    localparam logic [1:0] TYPE_80          = 2'h0;
    localparam logic [1:0] TYPE_40          = 2'h1;
    localparam logic [1:0] TYPE_20          = 2'h2;
    localparam logic [6:0] WIDTH_80         = 7'h50;
    localparam logic [6:0] WIDTH_40         = 7'h28;
    localparam logic [6:0] WIDTH_20         = 7'h14;
    // ============================================================
    // reset values
    localparam logic       RST_TEMPCO       = 1'b0;
    localparam logic       RST_TIME         = 1'b1;
    localparam logic       RST_COMP         = 1'b0;
    localparam logic [1:0] RST_TYPE         = 2'h0;
endpackage

// ==== rtl/ppo_print_options.sv ====
// print protocol option settings, set by decoded commands; all but compensation enable can be queried
// assumes the command parser delivers one-cycle cmd_valid with cmd_code and cmd_param
`timescale 1ns/10ps
module ppo_print_options
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // command port
    input  wire logic       cmd_valid,
    input  wire logic [2:0] cmd_code,
    input  wire logic [1:0] cmd_param,
    // query answer
    output logic            rsp_valid,
    output logic [1:0]      rsp_data,
    output logic            cmd_error,
    // settings to the print formatter
    output logic            print_tempco_in_heading,
    output logic            print_temperature_coefficient,
    output logic            print_time,
    output logic            temperature_compensation_enable,
    output logic [1:0]      printer_type,
    output logic [6:0]      line_width
);
    // ============================================================
    // settings storage
    logic       tempco_reg;
    logic       time_reg;
    logic       comp_reg;
    logic [1:0] type_reg;
    logic       type_ok;

    assign type_ok = (cmd_param <= ppo_pkg::TYPE_20);

    // coefficient heading flag
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            tempco_reg <= ppo_pkg::RST_TEMPCO;
        else if (cmd_valid && cmd_code == ppo_pkg::CMD_SET_TEMPCO)
            tempco_reg <= cmd_param[0];

    // time flag
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            time_reg <= ppo_pkg::RST_TIME;
        else if (cmd_valid && cmd_code == ppo_pkg::CMD_SET_TIME)
            time_reg <= cmd_param[0];

    // compensation enable, kept apart from the print flags
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            comp_reg <= ppo_pkg::RST_COMP;
        else if (cmd_valid && cmd_code == ppo_pkg::CMD_SET_COMP)
            comp_reg <= cmd_param[0];

    // printer type; a bad code leaves the old one so output format never breaks
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            type_reg <= ppo_pkg::RST_TYPE;
        else if (cmd_valid && cmd_code == ppo_pkg::CMD_SET_TYPE && type_ok)
            type_reg <= cmd_param;

    // ============================================================
    // query answers, one cycle after the command
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            rsp_valid <= 1'b0;
            rsp_data  <= 2'h0;
            cmd_error <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            cmd_error <= 1'b0;
            if (cmd_valid)
            begin
                case (cmd_code)
                    ppo_pkg::CMD_QRY_TEMPCO:
                    begin
                        rsp_valid <= 1'b1;
                        rsp_data  <= {1'b0, tempco_reg};
                    end
                    ppo_pkg::CMD_QRY_TIME:
                    begin
                        rsp_valid <= 1'b1;
                        rsp_data  <= {1'b0, time_reg};
                    end
                    ppo_pkg::CMD_QRY_TYPE:
                    begin
                        rsp_valid <= 1'b1;
                        rsp_data  <= type_reg;
                    end
                    ppo_pkg::CMD_SET_TYPE:
                        cmd_error <= !type_ok;
                    ppo_pkg::CMD_SET_TEMPCO, ppo_pkg::CMD_SET_TIME,
                    ppo_pkg::CMD_SET_COMP:
                        cmd_error <= 1'b0;
                    default:
                        cmd_error <= 1'b1;
                endcase
            end
        end

    // ============================================================
    // registered settings to the formatter
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            print_tempco_in_heading         <= ppo_pkg::RST_TEMPCO;
            print_temperature_coefficient   <= ppo_pkg::RST_TEMPCO & ppo_pkg::RST_COMP;
            print_time                      <= ppo_pkg::RST_TIME;
            temperature_compensation_enable <= ppo_pkg::RST_COMP;
            printer_type                    <= ppo_pkg::RST_TYPE;
            line_width                      <= ppo_pkg::WIDTH_80;
        end
        else
        begin
            print_tempco_in_heading         <= tempco_reg;
            print_temperature_coefficient   <= tempco_reg && comp_reg;
            print_time                      <= time_reg;
            temperature_compensation_enable <= comp_reg;
            printer_type                    <= type_reg;
            case (type_reg)
                ppo_pkg::TYPE_40: line_width <= ppo_pkg::WIDTH_40;
                ppo_pkg::TYPE_20: line_width <= ppo_pkg::WIDTH_20;
                default:          line_width <= ppo_pkg::WIDTH_80;
            endcase
        end

    // ============================================================
    // checks
    AST_TEMPCO_GATED: assert property (@(posedge core_clk) disable iff (!rst_b)
        print_temperature_coefficient |-> (print_tempco_in_heading
        && temperature_compensation_enable))
        else $error("coefficient printed without flag or compensation");
    AST_TYPE_REJECT: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cmd_valid && cmd_code == ppo_pkg::CMD_SET_TYPE && cmd_param == 2'h3)
        |=> (cmd_error && $stable(type_reg)))
        else $error("bad type code not rejected");
    AST_TYPE_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cmd_valid && cmd_code == ppo_pkg::CMD_SET_TYPE && type_ok)
        |=> ##1 (printer_type == $past(cmd_param, 2)))
        else $error("type not stored");
    AST_TYPE_QUERY: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cmd_valid && cmd_code == ppo_pkg::CMD_QRY_TYPE)
        |=> (rsp_valid && rsp_data == printer_type))
        else $error("type query wrong");
    AST_TEMPCO_QUERY: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cmd_valid && cmd_code == ppo_pkg::CMD_QRY_TEMPCO)
        |=> (rsp_valid && rsp_data == {1'b0, print_tempco_in_heading}))
        else $error("coefficient flag query wrong");
    AST_TIME_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cmd_valid && cmd_code == ppo_pkg::CMD_SET_TIME)
        |=> ##1 (print_time == $past(cmd_param[0], 2)))
        else $error("time flag not stored");
    AST_TEMPCO_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cmd_valid && cmd_code == ppo_pkg::CMD_SET_TEMPCO)
        |=> ##1 (print_tempco_in_heading == $past(cmd_param[0], 2)))
        else $error("coefficient flag not stored");
    AST_COMP_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cmd_valid && cmd_code == ppo_pkg::CMD_SET_COMP)
        |=> ##1 (temperature_compensation_enable == $past(cmd_param[0], 2)))
        else $error("compensation enable not stored");
    AST_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_b)
        (printer_type == ppo_pkg::TYPE_20) |-> (line_width == ppo_pkg::WIDTH_20))
        else $error("line width does not follow type");

    // ============================================================
    // answers, refusals and the formatter settings
    // the time answer reads the stored flag, just as the coefficient answer does
    AST_TIME_QUERY: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cmd_valid && cmd_code == ppo_pkg::CMD_QRY_TIME)
        |=> (rsp_valid && rsp_data == {1'b0, print_time}))
        else $error("time flag query wrong");
    // a stray answer would be read by the host as a reply to its next query
    AST_RSP_ONLY_QUERY: assert property (@(posedge core_clk) disable iff (!rst_b)
        rsp_valid |-> ($past(cmd_valid) && ($past(cmd_code) >= ppo_pkg::CMD_QRY_TEMPCO)))
        else $error("answer without a query");
    // an error pulse only ever answers a command that was taken
    AST_ERROR_ONLY_CMD: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_error |-> $past(cmd_valid))
        else $error("error pulse without a command");
    // a refused type must not reach the formatter either
    AST_TYPE_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cmd_valid && cmd_code == ppo_pkg::CMD_SET_TYPE && !type_ok)
        |=> ##1 $stable(printer_type))
        else $error("refused type reached the formatter");
    // the formatter never sees a code outside the three printer kinds
    AST_TYPE_LEGAL: assert property (@(posedge core_clk) disable iff (!rst_b)
        printer_type <= ppo_pkg::TYPE_20)
        else $error("printer type out of range");
    // both flags on means the coefficient must be printed
    AST_TEMPCO_SHOWN: assert property (@(posedge core_clk) disable iff (!rst_b)
        (print_tempco_in_heading && temperature_compensation_enable)
        |-> print_temperature_coefficient)
        else $error("coefficient suppressed with flag and compensation on");
    // compensation is a setting of its own and must not disturb the print flags
    AST_COMP_APART: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cmd_valid && cmd_code == ppo_pkg::CMD_SET_COMP)
        |=> ($stable(tempco_reg) && $stable(time_reg)))
        else $error("compensation set disturbed a print flag");
    // the 40 character width follows its type code
    AST_WIDTH_40: assert property (@(posedge core_clk) disable iff (!rst_b)
        (printer_type == ppo_pkg::TYPE_40) |-> (line_width == ppo_pkg::WIDTH_40))
        else $error("line width does not follow type 40");
    // the 80 character width follows its type code, the reset default
    AST_WIDTH_80: assert property (@(posedge core_clk) disable iff (!rst_b)
        (printer_type == ppo_pkg::TYPE_80) |-> (line_width == ppo_pkg::WIDTH_80))
        else $error("line width does not follow type 80");
endmodule // ppo_print_options

// ==== testbench/ppo_host_model.sv ====
// host model: sends decoded commands to the print option block
// assumes callers enter send or idle just after a rising core_clk edge
`timescale 1ns/10ps
module ppo_host_model
(
    // clock
    input  wire logic  core_clk,
    // command port
    output logic       cmd_valid,
    output logic [2:0] cmd_code,
    output logic [1:0] cmd_param
);
    // ============================================================
    // idle lines carry inverted junk so a stale code never looks valid
    task automatic idle();
        cmd_valid = 1'b0;
        cmd_code  = ~cmd_code;
        cmd_param = ~cmd_param;
    endtask
    // one command, held to the taking edge; type codes stay 0..2 unless refusal is meant
    task automatic send(input logic [2:0] c, input logic [1:0] p);
        cmd_valid = 1'b1;
        cmd_code  = c;
        cmd_param = p;
        @(posedge core_clk) #1;
    endtask
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code  = 3'h0;
        cmd_param = 2'h0;
    end
endmodule // ppo_host_model

// ==== testbench/ppo_print_options_tb.sv ====
// self-checking bench for the print protocol option block
// assumes ppo_host_model drives the command port; lfsr gives repeatable commands
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module ppo_print_options_tb;
    // ============================================================
    // signals and the bench's own copy of the settings
    logic        core_clk, rst_b, cmd_valid, rsp_valid, cmd_error;
    logic        print_tempco_in_heading, print_temperature_coefficient, print_time;
    logic        temperature_compensation_enable, coef, tm, comp;
    logic [2:0]  cmd_code;
    logic [1:0]  cmd_param, rsp_data, printer_type, typ;
    logic [6:0]  line_width;
    logic [31:0] lfsr = 32'h2164;
    int          err_total = 0;
    int          n_compared = 0;
    ppo_host_model ppo_host_model_i (.core_clk, .cmd_valid, .cmd_code, .cmd_param);
    ppo_print_options ppo_print_options_i (.core_clk, .rst_b, .cmd_valid, .cmd_code,
        .cmd_param, .rsp_valid, .rsp_data, .cmd_error, .print_tempco_in_heading,
        .print_temperature_coefficient, .print_time, .temperature_compensation_enable,
        .printer_type, .line_width);
    // ============================================================
    // expectations
    function automatic logic [6:0] width_of(input logic [1:0] t);
        return (t == ppo_pkg::TYPE_20) ? ppo_pkg::WIDTH_20 :
               (t == ppo_pkg::TYPE_40) ? ppo_pkg::WIDTH_40 : ppo_pkg::WIDTH_80;
    endfunction
    // one fibonacci step; the fixed seed keeps every run the same
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic finish_test();
        if (err_total == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk_settings();
        `CHK(print_tempco_in_heading, coef)
        `CHK(print_temperature_coefficient, coef & comp)
        `CHK(print_time, tm)
        `CHK(temperature_compensation_enable, comp)
        `CHK(printer_type, typ)
        `CHK(line_width, width_of(typ))
    endtask
    // answer is checked just after the taking edge; the model updates after the check
    task automatic do_cmd(input logic [2:0] c, input logic [1:0] p);
        ppo_host_model_i.send(c, p);
        `CHK(cmd_error, c == 3'h0 || (c == ppo_pkg::CMD_SET_TYPE && p == 2'h3))
        `CHK(rsp_valid, c >= ppo_pkg::CMD_QRY_TEMPCO)
        if (c == ppo_pkg::CMD_QRY_TEMPCO) `CHK(rsp_data, {1'b0, coef})
        if (c == ppo_pkg::CMD_QRY_TIME) `CHK(rsp_data, {1'b0, tm})
        if (c == ppo_pkg::CMD_QRY_TYPE) `CHK(rsp_data, typ)
        if (c == ppo_pkg::CMD_SET_TEMPCO) coef = p[0];
        if (c == ppo_pkg::CMD_SET_TIME) tm = p[0];
        if (c == ppo_pkg::CMD_SET_COMP) comp = p[0];
        if (c == ppo_pkg::CMD_SET_TYPE && p != 2'h3) typ = p;
    endtask
    // settings land one edge after the taking edge, so let one more edge pass
    task automatic settle();
        ppo_host_model_i.idle();
        @(posedge core_clk) #1;
        chk_settings();
    endtask
    // callers leave the command port idle first; the model copy returns to reset values
    task automatic do_reset();
        rst_b = 1'b0;
        {coef, tm, comp, typ} = {ppo_pkg::RST_TEMPCO, ppo_pkg::RST_TIME, ppo_pkg::RST_COMP,
            ppo_pkg::RST_TYPE};
        repeat (6) @(posedge core_clk);
        #1 chk_settings();
        `CHK(rsp_valid, 1'b0)
        `CHK(cmd_error, 1'b0)
        rst_b = 1'b1;
        // the first edge after release must leave every setting at its reset value
        @(posedge core_clk) #1;
        chk_settings();
        `CHK(rsp_valid, 1'b0)
    endtask
    // ============================================================
    // clock and main sequence
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        do_reset();
        do_cmd(ppo_pkg::CMD_QRY_TIME, 2'h0);
        do_cmd(ppo_pkg::CMD_QRY_TEMPCO, 2'h0);
        do_cmd(ppo_pkg::CMD_SET_TYPE, 2'h2);
        do_cmd(ppo_pkg::CMD_SET_TYPE, 2'h3);
        do_cmd(ppo_pkg::CMD_QRY_TYPE, 2'h0);
        settle();
        do_cmd(ppo_pkg::CMD_SET_TYPE, 2'h1);
        do_cmd(ppo_pkg::CMD_SET_TIME, 2'h2);
        do_cmd(ppo_pkg::CMD_QRY_TIME, 2'h0);
        do_cmd(ppo_pkg::CMD_QRY_TYPE, 2'h0);
        settle();
        do_cmd(3'h0, 2'h1);
        do_cmd(ppo_pkg::CMD_SET_TEMPCO, 2'h1);
        settle();
        do_cmd(ppo_pkg::CMD_SET_COMP, 2'h1);
        settle();
        for (int i = 0; i < 400; i++)
        begin
            lfsr = lfsr_next(lfsr);
            do_cmd(lfsr[2:0], lfsr[4:3]);
            if (lfsr[5])
                settle();
        end
        settle();
        do_reset();
        finish_test();
    end
endmodule // ppo_print_options_tb
